// *** design/rio_link_unit.sv ***
// two-wire remote i/o interface unit: input and output link channels
// Functional notes
// (RL1) 15+error mode: bit 15 is error; in pushed words it marks only a bad frame, not a timeout
// (RL2) 16 mode: input 15 lands in bit 15
// (RL3) point 15 lamp follows input only in 16 mode
// (RL4) error lit during fault, clears next good cycle; after a timeout the first good frame leaves it lit, the second clears it
// (RL5) terminal holds last data on error
// (RL6) terminal sends zeros after its power returns
// (RL7) only terminal checks output-direction errors
// (RL8) transfer typically 19.2 ms, at most 31 ms
// (RL9) controller holds outputs beyond 16 ms
// (RL10) group units take two or four words
// (RL11) mismatched delay class flags transmission error
// (RL12) each channel carries exactly sixteen points
// (RL13) one lamp per point, input or output
// (RL14) frame: start, 16 data, class, parity, stop
`timescale 1ns/10ps
`include "rio_params.svh"
module rio_link_unit #(
  parameter int FIFO_DEPTH  = 4,
  parameter int GROUP_POINTS = 16,
  parameter int BIT_CYC     =
    (`RIO_TYP_DELAY_US * `RIO_CLK_MHZ) / `RIO_FRAME_SLOTS,
  parameter int PERIOD_CYC  = `RIO_TYP_DELAY_US * `RIO_CLK_MHZ,
  parameter int TIMEOUT_CYC = `RIO_MAX_DELAY_US * `RIO_CLK_MHZ
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // configuration straps
  input  wire logic        mode_15_err,
  input  wire logic        speed_class,
  input  wire logic [3:0]  io_number,
  // link pins
  input  wire logic        link_signal_line,
  output logic             link_out_line,
  // received words toward the backplane
  output logic             in_word_valid,
  input  wire logic        in_word_ready,
  output logic [15:0]      in_word,
  output logic [15:0]      in_image,
  output logic             link_error,
  // output word from the backplane
  input  wire logic [15:0] out_word,
  // lamps
  output logic [15:0]      in_lamps,
  output logic [15:0]      out_lamps,
  output logic             err_lamp,
  // word allocation
  output logic [7:0]       first_word,
  output logic [2:0]       word_count
);

  initial begin
    if (GROUP_POINTS != 16 && GROUP_POINTS != 32 && GROUP_POINTS != 64)
      $error("rio_link_unit: GROUP_POINTS must be 16, 32 or 64"); // RL12
    if (BIT_CYC < 4 || PERIOD_CYC < BIT_CYC * `RIO_FRAME_SLOTS)
      $error("rio_link_unit: bit and period counts inconsistent");
    if (TIMEOUT_CYC <= PERIOD_CYC)
      $error("rio_link_unit: timeout must exceed frame period"); // RL8
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic frame_parity(input logic [16:0] bits);
    return ^bits;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  logic line_meta_r, line_sync_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      line_meta_r <= 1'b1;
      line_sync_r <= 1'b1;
    end else begin
      line_meta_r <= link_signal_line;
      line_sync_r <= line_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver

  rio_pkg::rx_state_t rx_state_r, rx_state_nxt;
  logic [31:0] rx_cnt_r, rx_cnt_nxt;
  logic [4:0]  rx_idx_r, rx_idx_nxt;
  logic [18:0] rx_sh_r, rx_sh_nxt;
  logic [31:0] to_cnt_r, to_cnt_nxt;
  logic [15:0] data_r, data_nxt;
  logic        err_r, err_nxt;
  logic        pend_r, pend_nxt;
  logic [15:0] pend_word_r, pend_word_nxt;
  logic        frame_done, frame_good, fifo_ready;
  logic [18:0] rx_frame;
  logic [15:0] word_now;

  assign rx_frame = {line_sync_r, rx_sh_r[18:1]};

  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_cnt_nxt   = rx_cnt_r;
    rx_idx_nxt   = rx_idx_r;
    rx_sh_nxt    = rx_sh_r;
    frame_done   = 1'b0;
    case (rx_state_r)
      rio_pkg::RX_IDLE: begin
        if (!line_sync_r) begin
          rx_cnt_nxt   = 32'(BIT_CYC / 2);
          rx_state_nxt = rio_pkg::RX_START;
        end
      end
      rio_pkg::RX_START: begin
        if (rx_cnt_r != '0) begin
          rx_cnt_nxt = rx_cnt_r - 1'b1;
        end else if (!line_sync_r) begin
          rx_cnt_nxt   = 32'(BIT_CYC - 1);
          rx_idx_nxt   = '0;
          rx_state_nxt = rio_pkg::RX_DATA;
        end else begin
          rx_state_nxt = rio_pkg::RX_IDLE; // glitch, not a start
        end
      end
      rio_pkg::RX_DATA: begin
        if (rx_cnt_r != '0) begin
          rx_cnt_nxt = rx_cnt_r - 1'b1;
        end else begin
          rx_sh_nxt  = rx_frame; // RL14
          rx_cnt_nxt = 32'(BIT_CYC - 1);
          rx_idx_nxt = rx_idx_r + 1'b1;
          if (rx_idx_r == 5'(`RIO_FRAME_BITS - 1)) begin
            frame_done   = 1'b1;
            rx_state_nxt = rio_pkg::RX_IDLE;
          end
        end
      end
      default: rx_state_nxt = rio_pkg::RX_IDLE;
    endcase
  end

  // stop, parity and delay class must all agree
  assign frame_good = rx_frame[`RIO_STOP_POS]
    & (frame_parity(rx_frame[16:0]) == rx_frame[`RIO_PARITY_POS]) // RL14
    & (rx_frame[`RIO_CLASS_POS] == speed_class); // RL11

  always_comb begin
    to_cnt_nxt = to_cnt_r + 1'b1;
    data_nxt   = data_r;
    err_nxt    = err_r;
    if (frame_done && frame_good) begin
      to_cnt_nxt = '0;
      data_nxt   = rx_frame[15:0]; // RL5
      err_nxt    = 1'b0; // RL4
    end else if (frame_done) begin
      err_nxt = 1'b1; // RL4
    end
    // silent line past worst delay is a fault; a good frame restarts count
    if (to_cnt_r >= 32'(TIMEOUT_CYC)) begin
      to_cnt_nxt = (frame_done && frame_good) ? '0 : 32'(TIMEOUT_CYC);
      err_nxt    = 1'b1; // RL8
    end
  end

  always_comb begin
    word_now = data_r;
    if (mode_15_err) begin
      word_now[`RIO_ERR_BIT_POS] = err_r; // RL1
    end // else input 15 passes through RL2
  end

  // a full fifo stalls the push; newer frames overwrite the pending word
  always_comb begin
    pend_nxt      = pend_r;
    pend_word_nxt = pend_word_r;
    if (pend_r && fifo_ready) begin
      pend_nxt = 1'b0;
    end
    if (frame_done) begin
      pend_nxt      = 1'b1;
      pend_word_nxt = mode_15_err
        ? {~frame_good | err_r & ~frame_good, rx_frame[14:0]} // RL1
        : rx_frame[15:0]; // RL2
      if (!frame_good) begin
        pend_word_nxt[14:0] = data_r[14:0];
        if (!mode_15_err) pend_word_nxt[15] = data_r[15];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_state_r  <= rio_pkg::RX_IDLE;
      rx_cnt_r    <= '0;
      rx_idx_r    <= '0;
      rx_sh_r     <= '0;
      to_cnt_r    <= '0;
      data_r      <= `RIO_DATA_RESET;
      err_r       <= 1'b0;
      pend_r      <= 1'b0;
      pend_word_r <= `RIO_DATA_RESET;
    end else begin
      rx_state_r  <= rx_state_nxt;
      rx_cnt_r    <= rx_cnt_nxt;
      rx_idx_r    <= rx_idx_nxt;
      rx_sh_r     <= rx_sh_nxt;
      to_cnt_r    <= to_cnt_nxt;
      data_r      <= data_nxt;
      err_r       <= err_nxt;
      pend_r      <= pend_nxt;
      pend_word_r <= pend_word_nxt;
    end
  end

  rio_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (pend_r),
    .in_ready  (fifo_ready),
    .in_data   (pend_word_r),
    .out_valid (in_word_valid),
    .out_ready (in_word_ready),
    .out_data  (in_word)
  );

  assign in_image   = word_now;
  assign link_error = err_r; // RL4
  assign err_lamp   = err_r; // RL4
  assign in_lamps   = {data_r[15] & ~mode_15_err, data_r[14:0]}; // RL3 RL13
  assign out_lamps  = out_word; // RL13

  ////////////////////////////////////////////////////////////////////////
  // transmitter, no error check on this direction (RL7)

  rio_pkg::tx_state_t tx_state_r, tx_state_nxt;
  logic [31:0] tx_per_r, tx_per_nxt;
  logic [31:0] tx_cnt_r, tx_cnt_nxt;
  logic [4:0]  tx_idx_r, tx_idx_nxt;
  logic [19:0] tx_sh_r, tx_sh_nxt;

  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_cnt_nxt   = tx_cnt_r;
    tx_idx_nxt   = tx_idx_r;
    tx_sh_nxt    = tx_sh_r;
    tx_per_nxt   = (tx_per_r == 32'(PERIOD_CYC - 1)) ? '0 : tx_per_r + 1'b1;
    case (tx_state_r)
      rio_pkg::TX_GAP: begin
        tx_sh_nxt = {20{1'b1}};
        if (tx_per_r == '0) begin
          // word sampled once per cycle; shorter pulses may be lost (RL9)
          tx_sh_nxt = {1'b1, frame_parity({speed_class, out_word}),
                       speed_class, out_word, 1'b0}; // RL14
          tx_cnt_nxt   = 32'(BIT_CYC - 1);
          tx_idx_nxt   = '0;
          tx_state_nxt = rio_pkg::TX_SEND;
        end
      end
      rio_pkg::TX_SEND: begin
        if (tx_cnt_r != '0) begin
          tx_cnt_nxt = tx_cnt_r - 1'b1;
        end else begin
          tx_cnt_nxt = 32'(BIT_CYC - 1);
          tx_sh_nxt  = {1'b1, tx_sh_r[19:1]};
          tx_idx_nxt = tx_idx_r + 1'b1;
          if (tx_idx_r == 5'(`RIO_FRAME_SLOTS - 1)) begin
            tx_state_nxt = rio_pkg::TX_GAP; // RL8
          end
        end
      end
      default: tx_state_nxt = rio_pkg::TX_GAP;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_state_r <= rio_pkg::TX_GAP;
      tx_per_r   <= '0;
      tx_cnt_r   <= '0;
      tx_idx_r   <= '0;
      tx_sh_r    <= {20{1'b1}};
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_per_r   <= tx_per_nxt;
      tx_cnt_r   <= tx_cnt_nxt;
      tx_idx_r   <= tx_idx_nxt;
      tx_sh_r    <= tx_sh_nxt;
    end
  end

  assign link_out_line = tx_sh_r[0];

  ////////////////////////////////////////////////////////////////////////
  // word allocation for group variants

  assign first_word = `RIO_WORD_BASE
    + 8'(io_number) * `RIO_WORD_STEP; // RL10
  assign word_count = 3'(GROUP_POINTS / 16); // RL10

endmodule // rio_link_unit

// *** include/rio_params.svh ***
// timing, frame layout and allocation constants for the two-wire link unit
`ifndef RIO_PARAMS_SVH
`define RIO_PARAMS_SVH

`define RIO_CLK_MHZ          200
`define RIO_TYP_DELAY_US     19200
`define RIO_MAX_DELAY_US     31000
`define RIO_MIN_INPUT_US     16000
`define RIO_FRAME_SLOTS      20
`define RIO_FRAME_BITS       19
`define RIO_DATA_BITS        16
`define RIO_CLASS_POS        16
`define RIO_PARITY_POS       17
`define RIO_STOP_POS         18
`define RIO_ERR_BIT_POS      15
`define RIO_WORD_BASE        8'h1E
`define RIO_WORD_STEP        8'h02
`define RIO_DATA_RESET       16'h0000

`endif

// *** include/rio_pkg.sv ***
// state types for the two-wire link unit
package rio_pkg;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10
  } rx_state_t;

  typedef enum logic [0:0] {
    TX_GAP  = 1'b0,
    TX_SEND = 1'b1
  } tx_state_t;

endpackage

// *** design/rio_fifo.sv ***
// small word fifo between the link receiver and the backplane
`timescale 1ns/10ps
module rio_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("rio_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0]      count_r, count_nxt;
  logic             push, pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    count_nxt  = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // storage needs no reset; empty flag guards it
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule // rio_fifo

// *** tb/rio_link_unit_asserts.sv ***
// port-level checker for the two-wire link unit
`timescale 1ns/10ps
module rio_link_unit_asserts #(
  parameter int GROUP_POINTS = 16
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // straps
  input wire logic        mode_15_err,
  input wire logic [3:0]  io_number,
  // link and words
  input wire logic        link_out_line,
  input wire logic        in_word_valid,
  input wire logic        in_word_ready,
  input wire logic [15:0] in_word,
  input wire logic [15:0] in_image,
  input wire logic        link_error,
  input wire logic [15:0] out_word,
  // lamps and allocation
  input wire logic [15:0] in_lamps,
  input wire logic [15:0] out_lamps,
  input wire logic        err_lamp,
  input wire logic [7:0]  first_word,
  input wire logic [2:0]  word_count
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
////////////////////////////////////////
  // start bit is one full bit time of 8 cycles in the sim build
  sequence start_edge; $fell(link_out_line); endsequence
  sequence start_held; (!link_out_line) [*8]; endsequence
  AST_TX_START: assert property (start_edge |-> start_held)
    else $error("start bit cut short");
  AST_ERR_LAMP: assert property (err_lamp == link_error)
    else $error("error lamp differs from flag");
  AST_OUT_LAMPS: assert property (out_lamps == out_word)
    else $error("output lamps differ from word");
  AST_FIRST_WORD: assert property (
    first_word == 8'h1E + {3'h0, io_number, 1'b0})
    else $error("first word wrong");
  AST_WORD_COUNT: assert property (
    word_count == 3'(GROUP_POINTS / 16))
    else $error("word count wrong");
  AST_IMG_ERR_BIT: assert property (
    mode_15_err |-> in_image[15] == link_error)
    else $error("bit 15 is not the error flag");
  AST_LAMP15_OFF: assert property (
    mode_15_err |-> in_lamps == {1'b0, in_image[14:0]})
    else $error("lamps wrong in 15 point mode");
  AST_LAMP16: assert property (
    !mode_15_err |-> in_lamps == in_image)
    else $error("lamps wrong in 16 point mode");
  AST_WORD_HOLD: assert property (in_word_valid && !in_word_ready
    |=> in_word_valid && $stable(in_word))
    else $error("word dropped while stalled");
endmodule // rio_link_unit_asserts

// *** tb/rio_terminal_model.sv ***
// behavioural remote terminal on the two-wire link
`timescale 1ns/10ps
module rio_terminal_model #(
  parameter int BIT_CYC = 8
) (
  // clock
  input  wire logic core_clk,
  // link pins
  output logic      line_r,
  input  wire logic rx_line
);
  initial line_r = 1'b1;
////////////////////////////////////////
  // caller picks the data; the bench sends zeros after one fault, random words after the others
  task automatic send(input logic [15:0] d, input logic cls,
                      input logic bad);
    logic [18:0] f;
    f = {1'b1, ^{cls, d} ^ bad, cls, d};
    line_r <= 1'b0;
    repeat (BIT_CYC) @(posedge core_clk);
    for (int i = 0; i < 19; i++) begin
      line_r <= f[i];
      repeat (BIT_CYC) @(posedge core_clk);
    end
  endtask
  // quiet run longer than any in-frame run of ones, so no midway join
  // sampled on falling edges, where the line has settled
  task automatic get(output logic [18:0] f, output logic ok);
    int n;
    int quiet;
    n = 0;
    quiet = 0;
    @(negedge core_clk);
    while (!(quiet > 20 * BIT_CYC && rx_line === 1'b0) && n < 2000) begin
      quiet = (rx_line === 1'b1) ? quiet + 1 : 0;
      @(negedge core_clk);
      n++;
    end
    ok = (n < 2000);
    repeat (BIT_CYC / 2) @(negedge core_clk);
    for (int i = 0; i < 19; i++) begin
      repeat (BIT_CYC) @(negedge core_clk);
      f[i] = rx_line;
    end
  endtask
endmodule // rio_terminal_model

// *** tb/rio_link_unit_tb.sv ***
// self-checking bench for the two-wire link unit
`timescale 1ns/10ps
module rio_link_unit_tb;
  logic        core_clk;
  logic        reset;
  logic        mode_15_err;
  logic        speed_class;
  logic [3:0]  io_number;
  logic        link_signal_line;
  logic        link_out_line;
  logic        in_word_valid;
  logic        in_word_ready;
  logic [15:0] in_word;
  logic [15:0] in_image;
  logic        link_error;
  logic [15:0] out_word;
  logic [15:0] in_lamps;
  logic [15:0] w;
  logic [15:0] d;
  logic [15:0] prev;
  logic [15:0] q [4];
  logic [18:0] f;
  logic        ok;
  int          err_total;
  int          check_count;
  int          seed;

  // gap between output frames outlasts any run of ones inside a frame
  rio_link_unit #(.GROUP_POINTS(32), .BIT_CYC(8), .PERIOD_CYC(400),
    .TIMEOUT_CYC(600)) rio_link_unit_i (.core_clk(core_clk),
    .reset(reset), .mode_15_err(mode_15_err), .speed_class(speed_class),
    .io_number(io_number), .link_signal_line(link_signal_line),
    .link_out_line(link_out_line), .in_word_valid(in_word_valid),
    .in_word_ready(in_word_ready), .in_word(in_word),
    .in_image(in_image), .link_error(link_error), .out_word(out_word),
    .in_lamps(in_lamps), .out_lamps(), .err_lamp(), .first_word(),
    .word_count());
  rio_terminal_model #(.BIT_CYC(8)) rio_terminal_model_i (
    .core_clk(core_clk), .line_r(link_signal_line),
    .rx_line(link_out_line));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // pushed word: bad frames keep held data, bit 15 flags in 15+error mode
  function automatic logic [15:0] exp_word(input logic m15,
                                           input logic bad,
                                           input logic [15:0] dd,
                                           input logic [15:0] held);
    if (bad) begin
      return m15 ? {1'b1, held[14:0]} : held;
    end
    return m15 ? {1'b0, dd[14:0]} : dd;
  endfunction
  task automatic close_out();
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_valid();
    int n;
    n = 0;
    while (in_word_valid !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 400) begin
      err_total++;
      close_out();
    end
  endtask
  task automatic pop();
    @(posedge core_clk);
    in_word_ready <= 1'b1;
    @(posedge core_clk);
    in_word_ready <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic xfer(input logic [15:0] dd, input logic cls,
                      input logic bad);
    @(posedge core_clk);
    io_number <= dd[3:0] % 4'hA;
    rio_terminal_model_i.send(dd, cls, bad);
    wait_valid();
    w = in_word;
    pop();
  endtask
////////////////////////////////////////
  initial begin
    seed = 51;
    err_total = 0;
    check_count = 0;
    reset = 1'b1;
    mode_15_err = 1'b0;
    speed_class = 1'b0;
    io_number = 4'h0;
    in_word_ready = 1'b0;
    out_word = 16'h0000;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    d = 16'($random(seed));
    xfer(d, 1'b0, 1'b0);
    check("word16", w, d);
    check("image16", in_image, d);
    check("lamps16", in_lamps, d);
    check("err_ok", 16'(link_error), 16'h0000);
    // bad parity in 16 point mode keeps every held bit
    prev = d;
    d = 16'($random(seed));
    xfer(d, 1'b0, 1'b1);
    check("word_hold16", w, exp_word(1'b0, 1'b1, d, prev));
    check("image_hold16", in_image, prev);
    check("err_hold16", 16'(link_error), 16'h0001);
    @(posedge core_clk);
    mode_15_err <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      d = 16'($random(seed));
      xfer(d, 1'b0, 1'b0);
      check("word15", w, exp_word(1'b1, 1'b0, d, prev));
    end
    check("err_ok15", 16'(link_error), 16'h0000);
    check("lamps15", in_lamps, {1'b0, d[14:0]});
    prev = d;
    d = 16'($random(seed));
    xfer(d, 1'b0, 1'b1);
    check("word_bad", w, exp_word(1'b1, 1'b1, d, prev));
    check("err_bad", 16'(link_error), 16'h0001);
    xfer(16'h0000, 1'b0, 1'b0);
    check("word_zero", w, 16'h0000);
    check("err_clear", 16'(link_error), 16'h0000);
    // good parity but wrong delay class, from a clean state
    d = 16'($random(seed));
    xfer(d, 1'b1, 1'b0);
    check("word_class", w, exp_word(1'b1, 1'b1, d, 16'h0000));
    check("err_class", 16'(link_error), 16'h0001);
    // backplane stalled while four frames land
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      q[i] = 16'($random(seed));
      rio_terminal_model_i.send(q[i], 1'b0, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      wait_valid();
      check("fifo", in_word, exp_word(1'b1, 1'b0, q[i], 16'h0000));
      pop();
    end
    @(posedge core_clk);
    out_word <= 16'($random(seed));
    rio_terminal_model_i.get(f, ok);
    check("tx_found", 16'(ok), 16'h0001);
    if (!ok) begin
      close_out();
    end
    check("tx_data", f[15:0], out_word);
    check("tx_class", 16'(f[16]), 16'(speed_class));
    check("tx_parity", 16'(f[17]), 16'(^f[16:0]));
    check("tx_stop", 16'(f[18]), 16'h0001);
    repeat (620) @(negedge core_clk);
    check("err_timeout", 16'(link_error), 16'h0001);
    close_out();
  end
endmodule // rio_link_unit_tb

bind rio_link_unit rio_link_unit_asserts #(.GROUP_POINTS(GROUP_POINTS))
  rio_link_unit_asserts_i (.core_clk(core_clk), .reset(reset),
  .mode_15_err(mode_15_err), .io_number(io_number),
  .link_out_line(link_out_line), .in_word_valid(in_word_valid),
  .in_word_ready(in_word_ready), .in_word(in_word),
  .in_image(in_image), .link_error(link_error), .out_word(out_word),
  .in_lamps(in_lamps), .out_lamps(out_lamps), .err_lamp(err_lamp),
  .first_word(first_word), .word_count(word_count));
